// >>> spg_pkg.sv
`default_nettype none
package spg_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_GAIN_HI = 8'h04;
    localparam logic [7:0] REG_GAIN_LO = 8'h08;
    localparam logic [7:0] REG_THRESH = 8'h0c;
    localparam logic [7:0] REG_FEED = 8'h10;
    localparam logic [7:0] REG_OFFSET = 8'h14;
    localparam logic [7:0] REG_ITC = 8'h18;
    localparam logic [7:0] REG_FULLV = 8'h1c;
    localparam logic [7:0] REG_VMAX = 8'h20;
    localparam logic [7:0] REG_SRCPOS = 8'h24;
    localparam logic [7:0] REG_STATUS = 8'h28;
    localparam logic [7:0] REG_APPLIED = 8'h2c;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_CONFIRM_BIT = 0;
    localparam int CTRL_MANUAL_BIT = 1;
    localparam int CTRL_FORCE_REF_BIT = 2;
    localparam int CTRL_ACK_BIT = 3;
    localparam int ST_REFERENCED_BIT = 0;
    localparam int ST_PARAM_ERR_BIT = 1;
    localparam int ST_FAULT_BIT = 2;
    localparam int ST_INTEG_BIT = 3;
    localparam int ST_MANUAL_BIT = 4;
    localparam int ST_BAND_LSB = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] GAIN_RST = 16'h03e8;
    localparam logic [15:0] THRESH_RST = 16'h01f4;
    localparam logic [7:0] FEED_RST = 8'h0a;
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [15:0] ITC_RST = 16'h0000;
    localparam logic [15:0] FULLV_RST = 16'h1f40;
    localparam logic [31:0] VMAX_RST = 32'h0000_2710;

    // ------------------------------------------------------------------
    // Accepted ranges and scaling
    // ------------------------------------------------------------------
    localparam int GAIN_MIN = 50;
    localparam int GAIN_MAX = 12000;
    localparam int THRESH_MIN = 20;
    localparam int THRESH_MAX = 500;
    localparam int FEED_MAX = 100;
    localparam int OFFSET_MIN_MV = -250;
    localparam int OFFSET_MAX_MV = 250;
    localparam int ITC_MIN_MS = 100;
    localparam int ITC_MAX_MS = 5000;
    localparam int FULLV_LIMIT_MV = 9000;
    localparam int PCT_FULL = 100;
    localparam int OUT_LIMIT_MV = 10000;
    localparam int PCOEF_SHIFT = 14;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int LOOP_CYCLE_US = 1000;
    localparam int US_PER_MS = 1000;

    // Gain band in use
    typedef enum logic [1:0] {
        SPG_BAND_LOW = 2'b00,
        SPG_BAND_MEAN = 2'b01,
        SPG_BAND_HIGH = 2'b10
    } spg_band_t;

endpackage
`default_nettype wire

// >>> spg_gain_if.sv
`default_nettype none
interface spg_gain_if;
    import spg_pkg::*;
    logic [31:0] speed_mag;
    logic [31:0] vmax;
    logic [15:0] thresh_pct;
    logic [15:0] gain_hi;
    logic [15:0] gain_lo;
    logic [15:0] applied_gain;
    spg_band_t band;

    modport selector(
        input speed_mag, vmax, thresh_pct, gain_hi, gain_lo,
        output applied_gain, band
    );
    modport loop(
        output speed_mag, vmax, thresh_pct, gain_hi, gain_lo,
        input applied_gain, band
    );
endinterface
`default_nettype wire

// >>> spg_gain_sel.sv
`default_nettype none
module spg_gain_sel
    import spg_pkg::*;
(
    // Gain selection link
    spg_gain_if.selector g
);

    // ------------------------------------------------------------------
    // Speed band decision
    // ------------------------------------------------------------------
    logic [47:0] thr_scaled;
    logic [47:0] spd_scaled;
    logic [16:0] gain_sum;

    // Compare 2*100*|v| against pct*vmax to avoid division
    always_comb begin
        thr_scaled = 48'(g.thresh_pct) * 48'(g.vmax);
        spd_scaled = 48'(g.speed_mag) * 48'(2 * PCT_FULL);
        gain_sum = 17'(g.gain_hi) + 17'(g.gain_lo);
        if (spd_scaled >= 48'(3) * thr_scaled) begin
            g.band = SPG_BAND_HIGH;
            g.applied_gain = g.gain_hi; // [RQ5]
        end else if (spd_scaled >= thr_scaled) begin
            g.band = SPG_BAND_MEAN;
            g.applied_gain = gain_sum[16:1]; // [RQ6]
        end else begin
            g.band = SPG_BAND_LOW;
            g.applied_gain = g.gain_lo; // [RQ7]
        end
    end

endmodule // spg_gain_sel
`default_nettype wire

// >>> spg_position_loop.sv
// Function
// RQ1: Both gains accepted only within 50..12000.
// RQ2: Both gains reset to 1000.
// RQ3: Switching threshold accepted only 20..500 percent.
// RQ4: Switching threshold resets to 500 percent.
// RQ5: Speed at/above 1.5 threshold: high gain.
// RQ6: Between half and 1.5 threshold: mean gain.
// RQ7: Below half threshold: low gain.
// RQ8: Coefficient is constant times voltage times gain.
// RQ9: Feed forward 0..100 percent, default 10.
// RQ10: Full feed forward cancels constant-speed error.
// RQ11: Signed offset within 250 mV added.
// RQ12: Parameters used only after confirmed transfer.
// RQ13: Forced reference in manual marks axis referenced.
// RQ14: Host selects manual, acknowledges, supplies position.
// RQ15: Integral contributes only while stopped; it accumulates only then, but the held term is added while moving too.
// RQ16: Integral time 100..5000 ms, zero disables.
// RQ17: Band chosen each cycle from speed magnitude.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`default_nettype none
module spg_position_loop
    import spg_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // References, measurement and axis state
    input wire logic i_cycle,
    input wire logic signed [31:0] i_pos_ref,
    input wire logic signed [31:0] i_spd_ref,
    input wire logic signed [31:0] i_pos_meas,
    input wire logic i_fault,
    // Analog setpoint towards the drive
    output logic signed [15:0] o_setpoint_mv,
    output logic o_setpoint_valid,
    // Reference point state
    output logic o_referenced,
    output logic o_soft_limit_en,
    output logic signed [31:0] o_preset_pos,
    output logic o_preset_valid
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] e_gain_hi;
        logic [15:0] e_gain_lo;
        logic [15:0] e_thresh;
        logic [7:0] e_feed;
        logic [15:0] e_offset;
        logic [15:0] e_itc;
        logic [15:0] e_fullv;
        logic [31:0] e_vmax;
        logic [31:0] src_pos;
        logic [15:0] a_gain_hi;
        logic [15:0] a_gain_lo;
        logic [15:0] a_thresh;
        logic [7:0] a_feed;
        logic [15:0] a_offset;
        logic [15:0] a_itc;
        logic [15:0] a_fullv;
        logic [31:0] a_vmax;
        logic manual;
        logic referenced;
        logic fault;
        logic param_err;
        logic signed [47:0] integ_acc;
        logic signed [15:0] setpoint;
        logic sp_valid;
        logic [31:0] preset_pos;
        logic preset_valid;
        logic [31:0] rdata;
    } spg_state_t;

    spg_state_t st;
    spg_state_t next_st;

    // Range check used for every confirmed parameter except the maximum speed, which is only checked for nonzero
    function automatic logic spg_in_range(input int v, input int lo, input int hi);
        spg_in_range = (v >= lo) && (v <= hi);
    endfunction

    // Clamp a wide signed sum to the analog output span
    function automatic logic signed [15:0] spg_clamp(input logic signed [71:0] v);
        if (v > 72'(OUT_LIMIT_MV)) begin
            spg_clamp = 16'(OUT_LIMIT_MV);
        end else if (v < 72'(-OUT_LIMIT_MV)) begin
            spg_clamp = 16'(-OUT_LIMIT_MV);
        end else begin
            spg_clamp = 16'(v);
        end
    endfunction

    // ------------------------------------------------------------------
    // Gain selection
    // ------------------------------------------------------------------
    spg_gain_if gif();

    // Magnitude so both directions select the same band
    assign gif.speed_mag = i_spd_ref[31] ? 32'(-i_spd_ref) : 32'(i_spd_ref); // [RQ17]
    assign gif.vmax = st.a_vmax;
    assign gif.thresh_pct = st.a_thresh;
    assign gif.gain_hi = st.a_gain_hi;
    assign gif.gain_lo = st.a_gain_lo;

    spg_gain_sel u_gain_sel (
        .g(gif.selector)
    );

    // ------------------------------------------------------------------
    // Loop arithmetic
    // ------------------------------------------------------------------
    logic signed [32:0] pos_err;
    logic signed [71:0] p_term;
    logic signed [71:0] ff_num;
    logic signed [71:0] ff_den;
    logic signed [71:0] ff_term;
    logic signed [71:0] i_den;
    logic signed [71:0] i_term;
    logic signed [71:0] out_sum;
    logic integ_on;
    logic stopped;
    logic entered_ok;

    // Terms of the analog setpoint, all from active parameters only
    always_comb begin
        pos_err = 33'(i_pos_ref) - 33'(i_pos_meas);
        // Coefficient is gain times full-speed voltage scaled by 2^-PCOEF_SHIFT
        p_term = (72'(pos_err) * $signed({1'b0, gif.applied_gain})
            * $signed({1'b0, st.a_fullv})) >>> PCOEF_SHIFT; // [RQ8]
        // At 100 percent this is exactly the voltage that runs the reference speed
        ff_num = 72'(i_spd_ref) * $signed({1'b0, st.a_fullv})
            * $signed({1'b0, st.a_feed}); // [RQ10]
        ff_den = 72'(PCT_FULL) * $signed({1'b0, st.a_vmax});
        ff_term = (st.a_vmax == 32'h0000_0000) ? 72'sd0 : ff_num / ff_den; // [RQ9]
        // Accumulator over one integral time constant worth of cycles
        i_den = $signed({1'b0, st.a_itc}) * 72'(US_PER_MS);
        i_term = (st.a_itc == 16'h0000) ? 72'sd0
            : (72'(st.integ_acc) * 72'(LOOP_CYCLE_US)) / i_den; // [RQ16]
        out_sum = p_term + ff_term + i_term + 72'($signed(st.a_offset)); // [RQ11]
        stopped = (i_spd_ref == 32'sh0000_0000) && !st.fault;
        integ_on = stopped && (st.a_itc != 16'h0000); // [RQ15]
    end

    // Every entered value must sit in its window before transfer
    always_comb begin
        entered_ok = spg_in_range(int'(st.e_gain_hi), GAIN_MIN, GAIN_MAX) // [RQ1]
            && spg_in_range(int'(st.e_gain_lo), GAIN_MIN, GAIN_MAX) // [RQ1]
            && spg_in_range(int'(st.e_thresh), THRESH_MIN, THRESH_MAX) // [RQ3]
            && spg_in_range(int'(st.e_feed), 0, FEED_MAX) // [RQ9]
            && spg_in_range(int'($signed(st.e_offset)), OFFSET_MIN_MV,
                OFFSET_MAX_MV) // [RQ11]
            && ((st.e_itc == 16'h0000)
                || spg_in_range(int'(st.e_itc), ITC_MIN_MS, ITC_MAX_MS)) // [RQ16]
            && spg_in_range(int'(st.e_fullv), 1, FULLV_LIMIT_MV - 1) // [RQ8]
            && (st.e_vmax != 32'h0000_0000);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rdata = 32'h0000_0000;
        next_st.sp_valid = 1'b0;
        next_st.preset_valid = 1'b0;

        // Register reads, answered in the next cycle
        if (i_rd) begin
            unique case (i_addr)
                REG_CTRL: next_st.rdata = 32'(st.manual) << CTRL_MANUAL_BIT;
                REG_GAIN_HI: next_st.rdata = 32'(st.e_gain_hi);
                REG_GAIN_LO: next_st.rdata = 32'(st.e_gain_lo);
                REG_THRESH: next_st.rdata = 32'(st.e_thresh);
                REG_FEED: next_st.rdata = 32'(st.e_feed);
                REG_OFFSET: next_st.rdata = 32'(st.e_offset);
                REG_ITC: next_st.rdata = 32'(st.e_itc);
                REG_FULLV: next_st.rdata = 32'(st.e_fullv);
                REG_VMAX: next_st.rdata = st.e_vmax;
                REG_SRCPOS: next_st.rdata = st.src_pos;
                REG_STATUS: next_st.rdata = (32'(st.referenced) << ST_REFERENCED_BIT)
                    | (32'(st.param_err) << ST_PARAM_ERR_BIT)
                    | (32'(st.fault) << ST_FAULT_BIT)
                    | (32'(integ_on) << ST_INTEG_BIT)
                    | (32'(st.manual) << ST_MANUAL_BIT)
                    | (32'(gif.band) << ST_BAND_LSB);
                REG_APPLIED: next_st.rdata = 32'(gif.applied_gain);
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        // Acknowledge clears the fault latch; a new fault wins below
        if (i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_ACK_BIT]) begin
            next_st.fault = 1'b0;
        end

        // Parameter writes land in the entered copy only; control register writes act directly
        if (i_wr) begin
            unique case (i_addr)
                REG_CTRL: begin
                    next_st.manual = i_wdata[CTRL_MANUAL_BIT];
                    if (i_wdata[CTRL_CONFIRM_BIT]) begin
                        if (entered_ok) begin
                            next_st.a_gain_hi = st.e_gain_hi; // [RQ12]
                            next_st.a_gain_lo = st.e_gain_lo;
                            next_st.a_thresh = st.e_thresh;
                            next_st.a_feed = st.e_feed;
                            next_st.a_offset = st.e_offset;
                            next_st.a_itc = st.e_itc;
                            next_st.a_fullv = st.e_fullv;
                            next_st.a_vmax = st.e_vmax;
                            next_st.param_err = 1'b0;
                        end else begin
                            next_st.param_err = 1'b1; // [RQ1] [RQ3]
                        end
                    end
                    // Forced reference needs manual mode and no pending fault
                    if (i_wdata[CTRL_FORCE_REF_BIT] && st.manual && !st.fault) begin
                        next_st.referenced = 1'b1; // [RQ13] [RQ14]
                        next_st.preset_pos = st.src_pos;
                        next_st.preset_valid = 1'b1;
                    end
                end
                REG_GAIN_HI: next_st.e_gain_hi = i_wdata[15:0];
                REG_GAIN_LO: next_st.e_gain_lo = i_wdata[15:0];
                REG_THRESH: next_st.e_thresh = i_wdata[15:0];
                REG_FEED: next_st.e_feed = i_wdata[7:0];
                REG_OFFSET: next_st.e_offset = i_wdata[15:0];
                REG_ITC: next_st.e_itc = i_wdata[15:0];
                REG_FULLV: next_st.e_fullv = i_wdata[15:0];
                REG_VMAX: next_st.e_vmax = i_wdata;
                REG_SRCPOS: next_st.src_pos = i_wdata;
                default: next_st.src_pos = st.src_pos;
            endcase
        end

        // Axis fault latches; set beats a same-cycle acknowledge
        if (i_fault) begin
            next_st.fault = 1'b1;
        end

        // One loop evaluation per control cycle strobe
        if (i_cycle) begin
            next_st.setpoint = spg_clamp(out_sum);
            next_st.sp_valid = 1'b1;
            if (st.a_itc == 16'h0000) begin
                next_st.integ_acc = 48'sd0; // [RQ16]
            end else if (integ_on) begin
                next_st.integ_acc = 48'(72'(st.integ_acc) + p_term); // [RQ15]
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
            st.e_gain_hi <= GAIN_RST; // [RQ2]
            st.e_gain_lo <= GAIN_RST;
            st.e_thresh <= THRESH_RST; // [RQ4]
            st.e_feed <= FEED_RST; // [RQ9]
            st.e_offset <= OFFSET_RST;
            st.e_itc <= ITC_RST;
            st.e_fullv <= FULLV_RST;
            st.e_vmax <= VMAX_RST;
            st.a_gain_hi <= GAIN_RST; // [RQ2]
            st.a_gain_lo <= GAIN_RST;
            st.a_thresh <= THRESH_RST; // [RQ4]
            st.a_feed <= FEED_RST;
            st.a_offset <= OFFSET_RST; // [RQ11]
            st.a_itc <= ITC_RST; // [RQ16]
            st.a_fullv <= FULLV_RST;
            st.a_vmax <= VMAX_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_rdata = st.rdata;
    assign o_setpoint_mv = st.setpoint;
    assign o_setpoint_valid = st.sp_valid;
    assign o_referenced = st.referenced;
    assign o_soft_limit_en = st.referenced; // [RQ13]
    assign o_preset_pos = st.preset_pos;
    assign o_preset_valid = st.preset_valid;

endmodule // spg_position_loop
`default_nettype wire

// >>> spg_loop_props.sv
`default_nettype none
module spg_loop_props
    import spg_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Loop and reference state
    input wire logic i_cycle,
    input wire logic signed [15:0] o_setpoint_mv,
    input wire logic o_setpoint_valid,
    input wire logic o_referenced,
    input wire logic o_soft_limit_en,
    input wire logic o_preset_valid
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_arst_n);

    // --------
    // Loop output
    // --------
    setpoint_strobe_a: assert property (i_cycle |=> o_setpoint_valid)
        else $error("setpoint strobe missing after control cycle");
    strobe_cause_a: assert property (o_setpoint_valid |-> $past(i_cycle))
        else $error("setpoint strobe without control cycle");
    setpoint_hold_a: assert property (!i_cycle |=> $stable(o_setpoint_mv))
        else $error("setpoint moved between control cycles");
    setpoint_clamp_a: assert property (o_setpoint_valid |->
        o_setpoint_mv <= OUT_LIMIT_MV && o_setpoint_mv >= -OUT_LIMIT_MV)
        else $error("setpoint beyond output limit");

    // --------
    // Reference point and readback
    // --------
    ref_mirror_a: assert property (o_soft_limit_en == o_referenced)
        else $error("soft limit enable differs from referenced");
    ref_sticky_a: assert property (o_referenced |=> o_referenced)
        else $error("referenced flag dropped");
    ref_rise_a: assert property ($rose(o_referenced) |-> o_preset_valid)
        else $error("referenced without preset strobe");
    preset_cause_a: assert property (o_preset_valid |->
        $past(i_wr) && $past(i_addr) == REG_CTRL)
        else $error("preset strobe without control write");
    applied_range_a: assert property ($past(i_rd) && $past(i_addr) == REG_APPLIED |->
        o_rdata >= GAIN_MIN && o_rdata <= GAIN_MAX)
        else $error("applied gain out of range");
    band_code_a: assert property ($past(i_rd) && $past(i_addr) == REG_STATUS |->
        o_rdata[9:8] != 2'b11)
        else $error("illegal gain band code");

    // Main scenarios reached
    cover property (o_preset_valid);
    cover property (o_setpoint_valid && o_setpoint_mv < 0);
    cover property ($past(i_rd) && $past(i_addr) == REG_STATUS && o_rdata[1]);
endmodule // spg_loop_props

bind spg_position_loop spg_loop_props u_props (
    .i_clk_sys, .i_arst_n, .i_addr, .i_wr, .i_rd, .o_rdata, .i_cycle, .o_setpoint_mv,
    .o_setpoint_valid, .o_referenced, .o_soft_limit_en, .o_preset_valid
);
`default_nettype wire

// >>> spg_drive_model.sv
`default_nettype none
module spg_drive_model #(
    parameter int MOVE_SHIFT = 4
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Analog setpoint from the loop
    input wire logic signed [15:0] i_setpoint_mv,
    input wire logic i_setpoint_valid,
    // Measured position back to the loop
    output logic signed [31:0] o_pos_meas
);
    timeunit 1ns;
    timeprecision 1ps;

    // Axis travel follows the commanded voltage, so error shrinks as it moves
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pos_meas <= '0;
        end else if (i_setpoint_valid) begin
            o_pos_meas <= o_pos_meas + 32'(i_setpoint_mv >>> MOVE_SHIFT);
        end
    end
endmodule // spg_drive_model
`default_nettype wire

// >>> tb_servo_position_loop_gain_control.sv
`default_nettype none
module tb_servo_position_loop_gain_control;
    import spg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk_sys = 0, i_arst_n = 0, i_wr = 0, i_rd = 0, i_cycle = 0, i_fault = 0;
    logic [7:0] i_addr = '0;
    logic [31:0] i_wdata = '0, o_rdata, ew, mw;
    logic signed [31:0] i_pos_ref = 0, i_spd_ref = 0, pos_meas, o_preset_pos;
    logic signed [15:0] o_setpoint_mv;
    logic o_setpoint_valid, o_referenced, o_soft_limit_en, o_preset_valid, rd_d = 0;
    logic [15:0] seed = 16'h002d;
    int err_count = 0, checks = 0;
    longint act[7] = '{1000, 1000, 500, 10, 0, 0, 8000};
    longint bad[7] = '{12001, 49, 501, 101, -251, 99, 9000};
    longint good[7] = '{2000, 600, 20, 100, -250, 0, 8000};
    longint sp[7] = '{995, 1000, 2995, 3000, -3000, -995, 0};
    longint acc = 0, t1, t2;
    longint slo[$], shi[$], pq[$];
    logic [31:0] rq[$], mq[$];

    spg_position_loop u_dut (
        .i_clk_sys, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_cycle,
        .i_pos_ref, .i_spd_ref, .i_pos_meas(pos_meas), .i_fault, .o_setpoint_mv,
        .o_setpoint_valid, .o_referenced, .o_soft_limit_en, .o_preset_pos, .o_preset_valid
    );
    spg_drive_model u_drv (
        .i_clk_sys, .i_arst_n, .i_setpoint_mv(o_setpoint_mv),
        .i_setpoint_valid(o_setpoint_valid), .o_pos_meas(pos_meas)
    );

    // --------
    // Helpers
    // --------
    initial begin
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic longint clp(input longint v);
        return v > OUT_LIMIT_MV ? OUT_LIMIT_MV : (v < -OUT_LIMIT_MV ? -OUT_LIMIT_MV : v);
    endfunction

    task automatic cmp(input logic signed [63:0] g, input longint lo, input longint hi);
        checks++;
        if (((g >= lo) && (g <= hi)) !== 1'b1) begin
            err_count++;
            $display("Error at %0t: got %h exp %h", $time, g, lo);
        end
    endtask

    task automatic wr(input logic [7:0] a, input longint d);
        i_addr <= a;
        i_wdata <= d[31:0];
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rq.push_back(e);
        mq.push_back(m);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        @(posedge i_clk_sys);
    endtask

    // One control cycle; notes the setpoint range the integral ordering allows
    task automatic cyc(input longint s, input longint e);
        longint a, m, g, p, v, itc;
        a = acc;
        itc = act[5];
        m = s < 0 ? -s : s;
        g = 200 * m >= 3 * act[2] * 10000 ? act[0] :
            (200 * m >= act[2] * 10000 ? (act[0] + act[1]) >>> 1 : act[1]);
        p = (e * g * act[6]) >>> 14;
        if (s == 0 && itc != 0)
            acc += p;
        v = p + s * act[6] * act[3] / (100 * 10000) + act[4];
        slo.push_back(clp(v + (itc != 0 ? a / itc : 0)));
        shi.push_back(clp(v + (itc != 0 ? acc / itc : 0)));
        i_pos_ref <= pos_meas + 32'(e);
        i_spd_ref <= 32'(s);
        i_cycle <= 1'b1;
        @(posedge i_clk_sys);
        i_cycle <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Result watcher: read data, setpoints and preset strobes against the notes
    always @(posedge i_clk_sys) rd_d <= i_rd;
    always @(negedge i_clk_sys) begin
        if (rd_d && rq.size() > 0) begin
            ew = rq.pop_front();
            mw = mq.pop_front();
            cmp($signed({32'h0, o_rdata & mw}), ew, ew);
        end
        if (o_setpoint_valid === 1'b1 && slo.size() > 0) begin
            t1 = slo.pop_front();
            t2 = shi.pop_front();
            cmp(o_setpoint_mv, t1 < t2 ? t1 : t2, t1 < t2 ? t2 : t1);
        end
        if (o_preset_valid === 1'b1 && pq.size() > 0) begin
            t1 = pq.pop_front();
            cmp(o_preset_pos, t1, t1);
        end
    end

    // Watchdog
    initial begin
        #20us;
        err_count++;
        complete_run;
    end

    // --------
    // Tests
    // --------
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        @(posedge i_clk_sys);
        for (int k = 0; k < 7; k++)
            rd(8'h04 + 8'(4 * k), '1, act[k][31:0]);
        rd(REG_VMAX, '1, VMAX_RST);
        rd(8'h30, '1, 32'h0);
        $display("test defaults done");
        for (int k = 0; k < 7; k++) begin
            wr(8'h04 + 8'(4 * k), bad[k]);
            wr(REG_CTRL, 1);
            rd(REG_STATUS, 32'h2, 32'h2);
            wr(8'h04 + 8'(4 * k), good[k]);
            rd(REG_APPLIED, '1, act[1][31:0]);
            wr(REG_CTRL, 1);
            act[k] = good[k];
            rd(REG_STATUS, 32'h2, 32'h0);
            rd(REG_APPLIED, '1, act[1][31:0]);
        end
        $display("test ranges done");
        repeat (28) begin
            seed = lfsr(seed);
            cyc(sp[seed % 7], longint'(seed[2:0]) - 4);
        end
        $display("test gain bands done");
        wr(REG_CTRL, 32'h2);
        rd(REG_CTRL, '1, 32'h2);
        i_fault <= 1'b1;
        @(posedge i_clk_sys);
        i_fault <= 1'b0;
        wr(REG_CTRL, 32'h6);
        rd(REG_STATUS, 32'h1, 32'h0);
        cmp({o_referenced, o_soft_limit_en}, 0, 0);
        wr(REG_CTRL, 32'ha);
        wr(REG_SRCPOS, -1234);
        pq.push_back(-1234);
        wr(REG_CTRL, 32'h6);
        rd(REG_STATUS, 32'h1, 32'h1);
        cmp({o_referenced, o_soft_limit_en}, 3, 3);
        $display("test forced reference done");
        wr(REG_ITC, 100);
        wr(REG_CTRL, 1);
        act[5] = 100;
        repeat (20) cyc(0, 3);
        repeat (4) cyc(995, 2);
        $display("test integral done");
        repeat (4) @(posedge i_clk_sys);
        cmp(slo.size() + rq.size() + pq.size(), 0, 0);
        complete_run;
    end
endmodule // tb_servo_position_loop_gain_control
`default_nettype wire
